// *** rtl/brk_idle_pkg.sv ***
`default_nettype none
package brk_idle_pkg;
	// ****************************************************
	// Register map (byte addresses, word aligned)
	// ****************************************************
	localparam logic [3:0] CTRL_OFS    = 4'h0;
	localparam logic [3:0] DIV_OFS     = 4'h4;
	localparam logic [3:0] STATUS_OFS  = 4'h8;
	localparam logic [3:0] COUNT_OFS   = 4'hc;
	// Control field positions
	localparam int BRK_BIT = 0;
	localparam int TEN_BIT = 1;
	localparam int WLS_BIT = 2;
	// Status field positions
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_BRK_BIT   = 1;
	localparam int ST_IDLE_BIT  = 2;
	localparam int ST_TXD_BIT   = 3;
	// Frame lengths in bit periods
	localparam logic [4:0] FRAME_BITS_SHORT = 5'h0a;
	localparam logic [4:0] FRAME_BITS_LONG  = 5'h0b;
	// Reset values
	localparam logic [2:0]  CTRL_RST = 3'h0;
	localparam logic [15:0] DIV_RST  = 16'h0010;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// *** rtl/brk_idle_tx.sv ***
// Added by the designer: the Avalon-MM register port and the register offsets.
`default_nettype none
module brk_idle_tx
	import brk_idle_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// Avalon-MM slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// Serial line
	output logic             TXD
);
	typedef enum logic [1:0] {S_IDLE, S_BREAK, S_IDLEFR} tx_state_e;

	// ****************************************************
	// Bus slave
	// ****************************************************
	logic             send_break_request_reg;
	logic             transmit_enable_bit_reg;
	logic             word_long_reg;
	logic [DIV_W-1:0] baud_rate_divider_reg;
	logic             brk_pending_reg;
	logic             idle_pending_reg;
	logic             ack_reg;
	logic [31:0]      rdata_next;
	tx_state_e        state_reg;
	logic [4:0]       bit_cnt_reg;
	logic [DIV_W-1:0] baud_cnt_reg;
	logic             tick;
	logic [4:0]       frame_len;
	logic             wr_ctrl;
	logic             brk_rise;
	logic             ten_rise;

	// One wait cycle per access keeps read data registered
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			ack_reg <= 1'b0;
		else
			ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			AVS_WAITREQUEST <= 1'b1;
		else
			AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_reg);
	end

	// Word hit on an accepted access; writes commit only at the edge
	// where the master sees waitrequest low, so a dropped request is inert
	function automatic logic acc_hit(
		input logic       req,
		input logic [3:0] adr,
		input logic [3:0] ofs
	);
		return req & (adr == ofs);
	endfunction

	assign wr_ctrl = acc_hit(AVS_WRITE & ack_reg, AVS_ADDRESS, CTRL_OFS)
		& AVS_BYTEENABLE[0];
	assign brk_rise = wr_ctrl & AVS_WRITEDATA[BRK_BIT]
		& ~send_break_request_reg;
	assign ten_rise = wr_ctrl & AVS_WRITEDATA[TEN_BIT]
		& ~transmit_enable_bit_reg;

	// Control register
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			send_break_request_reg  <= CTRL_RST[BRK_BIT];
			transmit_enable_bit_reg <= CTRL_RST[TEN_BIT];
			word_long_reg           <= CTRL_RST[WLS_BIT];
		end else if (wr_ctrl) begin
			send_break_request_reg  <= AVS_WRITEDATA[BRK_BIT];
			transmit_enable_bit_reg <= AVS_WRITEDATA[TEN_BIT];
			word_long_reg           <= AVS_WRITEDATA[WLS_BIT];
		end
	end

	// Baud divider register, low two byte lanes
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			baud_rate_divider_reg <= DIV_W'(DIV_RST);
		else if (acc_hit(AVS_WRITE & ack_reg, AVS_ADDRESS, DIV_OFS)) begin
			if (AVS_BYTEENABLE[0])
				baud_rate_divider_reg[7:0] <= AVS_WRITEDATA[7:0];
			if (AVS_BYTEENABLE[1])
				baud_rate_divider_reg[DIV_W-1:8] <=
					AVS_WRITEDATA[DIV_W-1:8];
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		rdata_next = UNMAPPED_DATA;
		unique case (AVS_ADDRESS)
			CTRL_OFS: begin
				rdata_next[BRK_BIT] = send_break_request_reg;
				rdata_next[TEN_BIT] = transmit_enable_bit_reg;
				rdata_next[WLS_BIT] = word_long_reg;
			end
			DIV_OFS:
				rdata_next[DIV_W-1:0] = baud_rate_divider_reg;
			STATUS_OFS: begin
				rdata_next[ST_BUSY_BIT] = (state_reg != S_IDLE);
				rdata_next[ST_BRK_BIT]  = brk_pending_reg;
				rdata_next[ST_IDLE_BIT] = idle_pending_reg;
				rdata_next[ST_TXD_BIT]  = TXD;
			end
			COUNT_OFS:
				rdata_next[4:0] = bit_cnt_reg;
			default:
				rdata_next = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			AVS_READDATA <= UNMAPPED_DATA;
		else if (AVS_READ & ~ack_reg)
			AVS_READDATA <= rdata_next;
	end

	// ****************************************************
	// Request capture
	// ****************************************************
	// Set wins over clear: a new request in the frame-start cycle is kept
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			brk_pending_reg <= 1'b0;
		else if (brk_rise)
			brk_pending_reg <= 1'b1;
		else if (state_reg == S_IDLE && !idle_pending_reg)
			brk_pending_reg <= 1'b0;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			idle_pending_reg <= 1'b0;
		else if (ten_rise)
			idle_pending_reg <= 1'b1;
		else if (state_reg == S_IDLE)
			idle_pending_reg <= 1'b0;
	end

	// ****************************************************
	// Bit timing and frame sequencer
	// ****************************************************
	assign frame_len = word_long_reg ? FRAME_BITS_LONG
		: FRAME_BITS_SHORT;
	assign tick = (baud_cnt_reg == '0);

	// Divider restarts at each frame so every frame is whole bit periods
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			baud_cnt_reg <= '0;
		else if (state_reg == S_IDLE || tick)
			baud_cnt_reg <= baud_rate_divider_reg;
		else
			baud_cnt_reg <= baud_cnt_reg - DIV_W'(1);
	end

	// Idle frame first, then break; one length count per frame, no doubling
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_reg   <= S_IDLE;
			bit_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					bit_cnt_reg <= frame_len;
					if (idle_pending_reg)
						state_reg <= S_IDLEFR;
					else if (brk_pending_reg || send_break_request_reg)
						state_reg <= S_BREAK;
				end
				S_BREAK, S_IDLEFR: begin
					if (tick) begin
						if (bit_cnt_reg == 5'h01)
							state_reg <= S_IDLE;
						else
							bit_cnt_reg <= bit_cnt_reg - 5'h01;
					end
				end
			endcase
		end
	end

	// Line low for the whole break including stop positions
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			TXD <= 1'b1;
		else
			TXD <= !(state_reg == S_BREAK);
	end

	// ****************************************************
	// Assertions
	// ****************************************************
	logic [20:0] low_len_reg;
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			low_len_reg <= '0;
		else if (!TXD)
			low_len_reg <= low_len_reg + 21'h1;
		else
			low_len_reg <= '0;
	end

	// Frame end and one bit period, shared by the checks below
	logic        frame_end;
	logic [20:0] bit_len;
	assign frame_end = tick & (bit_cnt_reg == 5'h01);
	assign bit_len   = 21'(baud_rate_divider_reg) + 21'h1;

	// Break length is checked exactly; a doubled frame fails here
	a_break_low_line: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_BREAK) |=> !TXD)
		else $error("line not low during break");
	a_break_len_short: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		($rose(TXD) && !word_long_reg && $stable(baud_rate_divider_reg))
		|-> low_len_reg == 21'(FRAME_BITS_SHORT) * bit_len)
		else $error("short break has wrong length");
	a_break_len_long: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		($rose(TXD) && word_long_reg && $stable(baud_rate_divider_reg))
		|-> low_len_reg == 21'(FRAME_BITS_LONG) * bit_len)
		else $error("long break has wrong length");
	a_break_start: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLE && brk_pending_reg && !idle_pending_reg)
		|=> state_reg == S_BREAK)
		else $error("pending break not started");
	a_break_repeat: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLE && send_break_request_reg && !idle_pending_reg)
		|=> state_reg == S_BREAK)
		else $error("held break not repeated");
	a_break_single: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_BREAK && frame_end && !wr_ctrl
			&& !send_break_request_reg && !brk_pending_reg)
		|=> ##1 state_reg != S_BREAK)
		else $error("extra break after single request");
	a_break_ends_high: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_BREAK && frame_end) |=> ##1 TXD)
		else $error("line not released after break");
	a_line_high_idle: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLE) |=> TXD)
		else $error("line low outside a break");
	a_idle_first: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLE && idle_pending_reg)
		|=> state_reg == S_IDLEFR)
		else $error("idle frame not sent");
	a_idle_then_brk: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLEFR && brk_pending_reg) |=> brk_pending_reg)
		else $error("break lost behind idle");
	a_idle_brk_order: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLEFR && frame_end && brk_pending_reg)
		|=> state_reg == S_IDLE && brk_pending_reg)
		else $error("break not queued after idle frame");
	a_idle_line_high: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(state_reg == S_IDLEFR) |=> TXD)
		else $error("idle frame not high");
	a_bus_one_wait: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		((AVS_READ || AVS_WRITE) && !ack_reg) |=> !AVS_WAITREQUEST)
		else $error("waitrequest not lowered for access");
	a_bus_wait_back: assert property (
		@(posedge CORE_CLK) disable iff (SYS_RST)
		ack_reg |=> AVS_WAITREQUEST)
		else $error("waitrequest low for two cycles");

	// Main scenarios reached
	c_break_sent: cover property (@(posedge CORE_CLK) $rose(TXD));
	c_idle_sent: cover property (@(posedge CORE_CLK) state_reg == S_IDLEFR);
	c_idle_brk: cover property (@(posedge CORE_CLK)
		state_reg == S_IDLEFR ##1 state_reg == S_IDLE
		##1 state_reg == S_BREAK);
	c_held_repeat: cover property (@(posedge CORE_CLK)
		state_reg == S_BREAK ##1 state_reg == S_IDLE
		##1 state_reg == S_BREAK);
	c_long_break: cover property (@(posedge CORE_CLK)
		$rose(TXD) && word_long_reg);
endmodule
`default_nettype wire

// *** tb/line_rx_model.sv ***
`default_nettype none
// Remote receiver: measures every low run on the serial line
module line_rx_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial line and measured result
	input  wire logic        txd,
	output logic             brk_done,
	output logic      [15:0] brk_len
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] low_reg;
	// Count low cycles, report the run once the line is high again
	always_ff @(posedge clk) begin
		brk_done <= 1'b0;
		if (rst) begin
			low_reg <= 16'h0000;
		end else if (txd === 1'b0) begin
			low_reg <= low_reg + 16'h0001;
		end else if (low_reg != 16'h0000) begin
			brk_done <= 1'b1;
			brk_len  <= low_reg;
			low_reg  <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench
	import brk_idle_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, rd, wr, txd, done, wreq;
	logic [3:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [15:0] len, div;
	logic [2:0]  wl;
	logic [4:0]  fbits;
	logic [15:0] exp_q[$];
	int          err_total, checked, seed, n;

	brk_idle_tx dut (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
		.AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .TXD(txd));
	line_rx_model rx (.clk(clk), .rst(rst), .txd(txd), .brk_done(done),
		.brk_len(len));

	// ****************************************************
	// Clock, reporting and bus tasks
	// ****************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic stall();
		err_total++;
		$display("[FAIL] wait exp done got timeout");
		complete_run();
	endtask

	task automatic cmp_word(input string s, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic cmp_len(input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] break exp %h got %h", e, g);
		end
	endtask

	// Hold request until waitrequest is sampled low, then release
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 100);
		if (k >= 100) stall();
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk); // Gap keeps one assignment per time step
	endtask

	task automatic ctl(input logic [2:0] c);
		bus(1'b1, CTRL_OFS, {29'h0, c});
	endtask

	// Wait for expected breaks, then watch a quiet spell for extras
	task automatic drain();
		int k;
		for (k = 0; k < 4000 && exp_q.size() != 0; k++) @(posedge clk);
		if (k >= 4000) stall();
		repeat (12 * (div + 1) + 20) @(posedge clk);
	endtask

	function automatic logic [15:0] frame(input logic [2:0] c);
		return (c[WLS_BIT] ? {11'h0, FRAME_BITS_LONG} :
			{11'h0, FRAME_BITS_SHORT}) * (div + 16'h1);
	endfunction

	// Oldest expected break against each measured one
	always @(posedge clk) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("[FAIL] break exp none got %h", len);
			end else begin
				cmp_len(exp_q.pop_front(), len);
			end
		end
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		seed = 71;
		err_total = 0;
		checked = 0;
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		div = 16'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, CTRL_OFS, 32'h0);
		cmp_word("ctrl", {29'h0, CTRL_RST}, q);
		bus(1'b0, DIV_OFS, 32'h0);
		cmp_word("div", {16'h0, DIV_RST}, q);
		bus(1'b0, 4'h1, 32'h0);
		cmp_word("unmapped", UNMAPPED_DATA, q);
		for (int i = 0; i < 2; i++) begin
			wl = i[0] ? 3'h4 : 3'h0;
			fbits = wl[WLS_BIT] ? FRAME_BITS_LONG : FRAME_BITS_SHORT;
			div = 16'h1 + {14'h0, 2'($random(seed))}; // Short bit periods
			bus(1'b1, DIV_OFS, {16'h0, div});
			ctl(wl | 3'h2);
			bus(1'b0, CTRL_OFS, 32'h0);
			cmp_word("ctrl", {29'h0, wl | 3'h2}, q);
			drain();
			bus(1'b0, COUNT_OFS, 32'h0);
			cmp_word("count", {27'h0, fbits}, q);
			exp_q.push_back(frame(wl));
			ctl(wl | 3'h3);
			ctl(wl | 3'h2);
			drain();
			// Idle request directly ahead of a break request
			exp_q.push_back(frame(wl));
			ctl(wl);
			ctl(wl | 3'h2);
			ctl(wl | 3'h3);
			ctl(wl | 3'h2);
			drain();
			// Held break bit, cleared during the second frame
			exp_q.push_back(frame(wl));
			exp_q.push_back(frame(wl));
			ctl(wl | 3'h3);
			for (n = 0; n < 2000 && exp_q.size() > 1; n++) @(posedge clk);
			for (; n < 2000 && txd !== 1'b0; n++) @(posedge clk);
			if (n >= 2000) stall();
			bus(1'b0, STATUS_OFS, 32'h0);
			cmp_word("status", 32'h1 << ST_BUSY_BIT, q);
			ctl(wl | 3'h2);
			drain();
			bus(1'b0, STATUS_OFS, 32'h0);
			cmp_word("status", 32'h1 << ST_TXD_BIT, q);
		end
		complete_run();
	end
endmodule
`default_nettype wire
